// >>> msv_supervisor.sv
// Operation
// - Single-wire mode only allowed with Rogowski sensor settings 0 or 1.
// - Allowed single-wire mode follows the line range error flag.
// - Single-wire mode uses apparent power for tamper and energy; here integrate_en and tamper_en stay low in it, as line_err is set.
// - Equivalent voltage is line peak times coefficient chosen by select field.
// - Apparent power is current RMS times equivalent voltage.
// - Supply below threshold holds all logic in reset except the supply and sigma-delta input synchronisers and the read data register.
// - Power below threshold raises no-load flag, readable in status.
// - Four no-load thresholds doubling from sensor-dependent base.
// - No-load stops power integration and disables tamper module.
// - No-load suppresses stepper pulses and drives no-load pin low.
// - Flag any bitstream stuck at one level for a whole window.
// - Stuck stream replaced by idle zero-valued pattern.
// - Pin readback differing from internal drive flags an error.
// - Source-signal errors also stop power integration.
// - Line range error on period out of band or missing peaks.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

module msv_supervisor #(
    parameter int PERIOD_SLOW_CYC = msv_pkg::PERIOD_SLOW,
    parameter int PERIOD_FAST_CYC = msv_pkg::PERIOD_FAST
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [msv_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    output logic                             irq,
    input  wire logic                        supply_low,
    input  wire logic [msv_pkg::SD_N-1:0]    sd_in,
    output logic      [msv_pkg::SD_N-1:0]    sd_out,
    input  wire logic                        voltage_peak,
    input  wire logic                        vrms_below_on,
    input  wire logic                        vrms_above_off,
    input  wire logic [15:0]                 v_rms,
    input  wire logic [15:0]                 i_rms,
    input  wire logic [31:0]                 active_power,
    input  wire logic [15:0]                 full_scale_line_peak,
    output logic      [31:0]                 integrate_power,
    output logic                             integrate_en,
    output logic                             apparent_sel,
    output logic                             tamper_en,
    input  wire logic                        stepper_pos_drv,
    input  wire logic                        stepper_neg_drv,
    input  wire logic                        energy_pulse_drv,
    input  wire logic                        stepper_drive_pos_in,
    input  wire logic                        stepper_drive_neg_in,
    input  wire logic                        energy_pulse_in,
    output logic                             stepper_drive_pos,
    output logic                             stepper_drive_neg,
    output logic                             energy_pulse_pin,
    output logic                             no_load_pin
);

    msv_pkg::msv_cfg_s          cfg_q;
    msv_pkg::msv_stat_s         stat;
    logic [msv_pkg::IRQ_W-1:0]  irq_stat_q;
    logic [msv_pkg::IRQ_W-1:0]  irq_mask_q;
    logic [msv_pkg::IRQ_W-1:0]  ev_prev_q;
    logic [msv_pkg::IRQ_W-1:0]  ev_now;
    logic [31:0]                prdata_q;
    logic [1:0]                 sup_sync_q;
    logic                       halt;
    logic [msv_pkg::SD_N-1:0]   sd_s1_q;
    logic [msv_pkg::SD_N-1:0]   sd_s2_q;
    logic [msv_pkg::SD_N-1:0]   stuck;
    logic [msv_pkg::WIN_W-1:0]  win_cnt_q;
    logic                       win_end;
    logic [msv_pkg::PERIOD_W-1:0] per_cnt_q;
    logic [1:0]                 fast_cnt_q;
    logic                       band_err_q;
    logic                       volt_err_q;
    logic                       line_err;
    logic                       single_wire_mode;
    logic [15:0]                fixed_voltage_coefficient;
    logic [31:0]                peak_prod;
    logic [15:0]                v_eff;
    logic [31:0]                apparent;
    logic [31:0]                vi_prod;
    logic [31:0]                nl_base;
    logic [34:0]                nl_thr;
    logic                       no_load_q;
    logic [31:0]                integ_q;
    logic [2:0]                 pin_s1_q;
    logic [2:0]                 pin_s2_q;
    logic [2:0]                 out_q;
    logic [2:0]                 out_d1_q;
    logic [2:0]                 out_d2_q;
    logic                       pin_err_q;
    logic                       src_err;
    logic                       block_out;
    logic                       acc;
    logic                       addr_ok;

    // Supply monitor is asynchronous to pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_sync_q <= 2'h0;
        end else begin
            sup_sync_q <= {sup_sync_q[0], supply_low};
        end
    end
    assign halt = sup_sync_q[1];

    // APB slave, zero wait states
    assign acc     = psel && penable;
    assign addr_ok = (paddr == msv_pkg::OFF_CONFIG) || (paddr == msv_pkg::OFF_STATUS) ||
                     (paddr == msv_pkg::OFF_IRQ_STAT) || (paddr == msv_pkg::OFF_IRQ_MASK);
    assign pready  = 1'b1;
    assign pslverr = acc && !addr_ok;
    assign prdata  = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q      <= msv_pkg::CONFIG_RST;
            irq_mask_q <= msv_pkg::IRQ_MASK_RST;
        end else if (halt) begin
            cfg_q      <= msv_pkg::CONFIG_RST;
            irq_mask_q <= msv_pkg::IRQ_MASK_RST;
        end else if (acc && pwrite) begin
            if (paddr == msv_pkg::OFF_CONFIG) begin
                cfg_q <= pwdata[msv_pkg::CFG_W-1:0];
            end
            if (paddr == msv_pkg::OFF_IRQ_MASK) begin
                irq_mask_q <= pwdata[msv_pkg::IRQ_W-1:0];
            end
        end
    end

    // Read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                msv_pkg::OFF_CONFIG:   prdata_q <= {26'h0, cfg_q};
                msv_pkg::OFF_STATUS:   prdata_q <= {25'h0, stat};
                msv_pkg::OFF_IRQ_STAT: prdata_q <= {27'h0, irq_stat_q};
                msv_pkg::OFF_IRQ_MASK: prdata_q <= {27'h0, irq_mask_q};
                default:               prdata_q <= 32'h0;
            endcase
        end
    end

    // Sticky events; a new event wins over the read clear
    assign ev_now = {pin_err_q, |stuck, no_load_q, line_err, single_wire_mode};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_prev_q  <= '0;
            irq_stat_q <= '0;
        end else if (halt) begin
            ev_prev_q  <= '0;
            irq_stat_q <= '0;
        end else begin
            ev_prev_q <= ev_now;
            if (acc && !pwrite && paddr == msv_pkg::OFF_IRQ_STAT) begin
                irq_stat_q <= ev_now & ~ev_prev_q;
            end else begin
                irq_stat_q <= irq_stat_q | (ev_now & ~ev_prev_q);
            end
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // Sigma-delta inputs synchronised, then watched per stream
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sd_s1_q <= '0;
            sd_s2_q <= '0;
        end else begin
            sd_s1_q <= sd_in;
            sd_s2_q <= sd_s1_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_cnt_q <= '0;
        end else if (halt) begin
            win_cnt_q <= '0;
        end else begin
            win_cnt_q <= win_cnt_q + 1'b1;
        end
    end
    assign win_end = (win_cnt_q == msv_pkg::WIN_W'(msv_pkg::WIN_CYC - 1));

    genvar gi;
    generate
        for (gi = 0; gi < msv_pkg::SD_N; gi++) begin : g_sd
            msv_sd_watch u_watch (
                .pclk    (pclk),
                .presetn (presetn),
                .halt    (halt),
                .win_end (win_end),
                .bit_in  (sd_s2_q[gi]),
                .bit_out (sd_out[gi]),
                .stuck   (stuck[gi])
            );
        end
    endgenerate

    // Line period band check between voltage peaks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt_q  <= '0;
            fast_cnt_q <= 2'h0;
            band_err_q <= 1'b0;
        end else if (halt) begin
            per_cnt_q  <= '0;
            fast_cnt_q <= 2'h0;
            band_err_q <= 1'b0;
        end else if (voltage_peak) begin
            per_cnt_q <= '0;
            if (32'(per_cnt_q) >= PERIOD_SLOW_CYC) begin
                band_err_q <= 1'b1;
                fast_cnt_q <= 2'h0;
            end else if (32'(per_cnt_q) < PERIOD_FAST_CYC) begin
                if (fast_cnt_q + 2'h1 >= msv_pkg::FAST_REPEAT) begin
                    band_err_q <= 1'b1;
                    fast_cnt_q <= msv_pkg::FAST_REPEAT;
                end else begin
                    fast_cnt_q <= fast_cnt_q + 2'h1;
                end
            end else begin
                band_err_q <= 1'b0;
                fast_cnt_q <= 2'h0;
            end
        end else if (32'(per_cnt_q) >= PERIOD_SLOW_CYC) begin
            band_err_q <= 1'b1;
        end else begin
            per_cnt_q <= per_cnt_q + 1'b1;
        end
    end

    // Low line voltage with hysteresis
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            volt_err_q <= 1'b0;
        end else if (halt) begin
            volt_err_q <= 1'b0;
        end else if (vrms_below_on) begin
            volt_err_q <= 1'b1;
        end else if (vrms_above_off) begin
            volt_err_q <= 1'b0;
        end
    end
    assign line_err = band_err_q || volt_err_q;

    assign single_wire_mode = (cfg_q.current_sensor_config <= msv_pkg::SNS_ROG_MAX) &&
                              line_err;

    always_comb begin
        unique case (cfg_q.fixed_voltage_select)
            2'h0: fixed_voltage_coefficient = msv_pkg::FVC_0;
            2'h1: fixed_voltage_coefficient = msv_pkg::FVC_1;
            2'h2: fixed_voltage_coefficient = msv_pkg::FVC_2;
            2'h3: fixed_voltage_coefficient = msv_pkg::FVC_3;
        endcase
    end
    assign peak_prod = full_scale_line_peak * fixed_voltage_coefficient;
    assign v_eff     = single_wire_mode ? peak_prod[31:16] : v_rms;
    assign apparent = i_rms * v_eff;
    assign vi_prod  = apparent;

    // No-load threshold doubles per level step
    assign nl_base = (cfg_q.current_sensor_config <= msv_pkg::SNS_ROG_MAX) ?
                     msv_pkg::NL_BASE_ROG : msv_pkg::NL_BASE_CT;
    assign nl_thr  = {3'h0, nl_base} << cfg_q.no_load_level_select;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            no_load_q <= 1'b0;
        end else if (halt) begin
            no_load_q <= 1'b0;
        end else begin
            no_load_q <= ({3'h0, vi_prod} < nl_thr);
        end
    end

    assign src_err = (|stuck) || pin_err_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            integ_q <= 32'h0;
        end else if (halt) begin
            integ_q <= 32'h0;
        end else begin
            integ_q <= single_wire_mode ? apparent : active_power;
        end
    end
    assign integrate_power = integ_q;
    assign apparent_sel    = single_wire_mode;
    assign integrate_en    = !(no_load_q || line_err || src_err) && !halt;
    assign tamper_en       = !(no_load_q || line_err || src_err) && !halt;
    assign no_load_pin     = !no_load_q && !halt;

    // Output pins, held low on no-load or line error
    assign block_out = no_load_q || line_err;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 3'h0;
        end else if (halt) begin
            out_q <= 3'h0;
        end else begin
            out_q <= {energy_pulse_drv, stepper_neg_drv, stepper_pos_drv} & {3{!block_out}};
        end
    end
    assign stepper_drive_pos = out_q[0];
    assign stepper_drive_neg = out_q[1];
    assign energy_pulse_pin  = out_q[2];

    // Readback aligned with two-stage delayed drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            out_d1_q <= 3'h0;
            out_d2_q <= 3'h0;
            pin_err_q <= 1'b0;
        end else if (halt) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            out_d1_q <= 3'h0;
            out_d2_q <= 3'h0;
            pin_err_q <= 1'b0;
        end else begin
            pin_s1_q <= {energy_pulse_in, stepper_drive_neg_in, stepper_drive_pos_in};
            pin_s2_q <= pin_s1_q;
            out_d1_q <= out_q;
            out_d2_q <= out_d1_q;
            pin_err_q <= |(pin_s2_q ^ out_d2_q);
        end
    end

    assign stat = '{pin_mismatch: pin_err_q, stuck: stuck, no_load_flag: no_load_q,
                    line_range_error: line_err, single_wire_mode: single_wire_mode};

    a_wire_mode_gate: assert property (@(posedge pclk) disable iff (!presetn)
        single_wire_mode |-> (cfg_q.current_sensor_config <= 2'h1) && line_err)
        else $error("single-wire mode outside Rogowski setting");
    a_wire_mode_follow: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_q.current_sensor_config <= 2'h1 && line_err) |-> single_wire_mode)
        else $error("single-wire mode not entered");
    a_apparent_use: assert property (@(posedge pclk) disable iff (!presetn)
        (single_wire_mode && !halt) |=> integrate_power == $past(apparent))
        else $error("apparent power not used");
    a_veq_value: assert property (@(posedge pclk) disable iff (!presetn)
        (single_wire_mode && cfg_q.fixed_voltage_select == 2'h2) |->
        v_eff == 16'((32'(full_scale_line_peak) * 32'h6c02) >> 16))
        else $error("equivalent voltage wrong");
    a_supply_hold: assert property (@(posedge pclk) disable iff (!presetn)
        halt |=> integrate_power == 32'h0 && !irq && cfg_q == 6'h00)
        else $error("logic not held on low supply");
    a_noload_out: assert property (@(posedge pclk) disable iff (!presetn)
        no_load_q |-> !no_load_pin ##1 (!stepper_drive_pos && !stepper_drive_neg))
        else $error("outputs active during no-load");
    a_integ_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (no_load_q || line_err || (|stuck) || pin_err_q) |-> !integrate_en && !tamper_en)
        else $error("integration not suspended");
    a_idle_pattern: assert property (@(posedge pclk) disable iff (!presetn)
        (stuck[0] && $past(stuck[0]) && !halt) |=> sd_out[0] != $past(sd_out[0]))
        else $error("stuck stream not replaced");
    a_pin_check: assert property (@(posedge pclk) disable iff (!presetn)
        (!halt && out_q != {energy_pulse_in, stepper_drive_neg_in, stepper_drive_pos_in})
        ##1 !halt [*2] |=> pin_err_q) else $error("pin mismatch not flagged");
    a_period_slow: assert property (@(posedge pclk) disable iff (!presetn)
        (32'(per_cnt_q) >= PERIOD_SLOW_CYC && !halt) |=> band_err_q)
        else $error("missing peaks not flagged");

endmodule : msv_supervisor

`default_nettype wire

// >>> msv_pkg.sv
package msv_pkg;

    // Register map, byte addresses on the APB side
    localparam int             ADDR_W       = 8;
    localparam logic [7:0]     OFF_CONFIG   = 8'h00;
    localparam logic [7:0]     OFF_STATUS   = 8'h04;
    localparam logic [7:0]     OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0]     OFF_IRQ_MASK = 8'h0c;

    // Config field positions and reset value
    localparam int             CFG_SNS_LSB  = 0;
    localparam int             CFG_FVS_LSB  = 2;
    localparam int             CFG_NLS_LSB  = 4;
    localparam int             CFG_W        = 6;
    localparam logic [5:0]     CONFIG_RST   = 6'h00;

    // Interrupt status / mask layout
    localparam int             IRQ_W        = 5;
    localparam int             IRQ_SWIRE    = 0;
    localparam int             IRQ_LINE     = 1;
    localparam int             IRQ_NOLOAD   = 2;
    localparam int             IRQ_STUCK    = 3;
    localparam int             IRQ_PIN      = 4;
    localparam logic [4:0]     IRQ_MASK_RST = 5'h00;

    // Sigma-delta streams: voltage, primary current, secondary current
    localparam int             SD_N         = 3;
    localparam int             WIN_CYC      = 128;
    localparam int             WIN_W        = 7;

    // Sensor settings up to this value are Rogowski coils
    localparam logic [1:0]     SNS_ROG_MAX  = 2'h1;

    // Fixed voltage coefficients, unsigned Q0.16
    localparam logic [15:0]    FVC_0        = 16'h5c01;
    localparam logic [15:0]    FVC_1        = 16'h63fe;
    localparam logic [15:0]    FVC_2        = 16'h6c02;
    localparam logic [15:0]    FVC_3        = 16'h73ff;

    // No-load base thresholds on the V*I product, Q0.32 of full scale
    localparam logic [31:0]    NL_BASE_ROG  = 32'h01262025;
    localparam logic [31:0]    NL_BASE_CT   = 32'h00ef1349;

    // Line period band, in clock cycles between voltage peaks
    localparam int             PERIOD_SLOW  = 131072;
    localparam int             PERIOD_FAST  = 32768;
    localparam int             PERIOD_W     = 18;
    localparam logic [1:0]     FAST_REPEAT  = 2'h3;

    typedef struct packed {
        logic [1:0] no_load_level_select;
        logic [1:0] fixed_voltage_select;
        logic [1:0] current_sensor_config;
    } msv_cfg_s;

    typedef struct packed {
        logic       pin_mismatch;
        logic [2:0] stuck;
        logic       no_load_flag;
        logic       line_range_error;
        logic       single_wire_mode;
    } msv_stat_s;

endpackage : msv_pkg

// >>> msv_sd_watch.sv
`timescale 1ns/10ps
`default_nettype none

module msv_sd_watch (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic halt,
    input  wire logic win_end,
    input  wire logic bit_in,
    output logic      bit_out,
    output logic      stuck
);

    logic seen0_q;
    logic seen1_q;
    logic stuck_q;
    logic idle_q;
    logic out_q;

    // Activity seen in the current window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen0_q <= 1'b0;
            seen1_q <= 1'b0;
        end else if (halt || win_end) begin
            seen0_q <= 1'b0;
            seen1_q <= 1'b0;
        end else begin
            seen0_q <= seen0_q | ~bit_in;
            seen1_q <= seen1_q | bit_in;
        end
    end

    // Verdict at window end, held through the next window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stuck_q <= 1'b0;
        end else if (halt) begin
            stuck_q <= 1'b0;
        end else if (win_end) begin
            stuck_q <= ~((seen0_q | ~bit_in) & (seen1_q | bit_in));
        end
    end

    // Alternating pattern averages to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_q <= 1'b0;
            out_q  <= 1'b0;
        end else if (halt) begin
            idle_q <= 1'b0;
            out_q  <= 1'b0;
        end else begin
            idle_q <= ~idle_q;
            out_q  <= stuck_q ? idle_q : bit_in;
        end
    end

    assign bit_out = out_q;
    assign stuck   = stuck_q;

endmodule : msv_sd_watch

`default_nettype wire

// >>> msv_front_model.sv
`timescale 1ns/10ps
`default_nettype none

module msv_front_model (
    input  wire logic       pclk,
    input  wire logic [2:0] stuck_ch,
    input  wire logic       stuck_one,
    input  wire logic       pin_short,
    input  wire logic       no_peak,
    input  wire logic       pos_pin,
    input  wire logic       neg_pin,
    input  wire logic       led_pin,
    output logic      [2:0] sd_bits,
    output logic            peak,
    output logic            pos_rb,
    output logic            neg_rb,
    output logic            led_rb
);
    int mseed = 20;
    int cnt = 0;
    initial begin
        sd_bits = 3'h0;
        peak = 1'b0;
    end
    // Peaks every 200 cycles keep the line period in band
    always @(posedge pclk) begin
        cnt <= (cnt == 199) ? 0 : cnt + 1;
        peak <= (cnt == 199) && !no_peak;
        sd_bits <= (3'($random(mseed)) & ~stuck_ch) | (stuck_ch & {3{stuck_one}});
    end
    // A shorted pin reads back as ground
    assign pos_rb = pin_short ? 1'b0 : pos_pin;
    assign neg_rb = pin_short ? 1'b0 : neg_pin;
    assign led_rb = pin_short ? 1'b0 : led_pin;
endmodule : msv_front_model

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    localparam logic [7:0] ST = msv_pkg::OFF_STATUS;
    logic pclk, presetn, psel, penable, pwrite, sl, vb, va, pd, nd, ed, nopk, ee, sh, s1;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, ip, ap, q, k;
    logic [15:0] vr, ir, pk;
    logic [2:0] sdi, sdo, sc;
    logic [1:0] cs;
    logic ready, err, irq, vpeak, ie, asel, te, pp, np, lp, nlp, prb, nrb, lrb;
    int seed = 20;
    int n_mismatch = 0;
    int check_count = 0;
    logic [15:0] kt [4] = '{msv_pkg::FVC_0, msv_pkg::FVC_1, msv_pkg::FVC_2, msv_pkg::FVC_3};

    msv_supervisor #(.PERIOD_SLOW_CYC(400), .PERIOD_FAST_CYC(100)) i_msv_supervisor (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(ready), .pslverr(err),
        .irq(irq), .supply_low(sl), .sd_in(sdi), .sd_out(sdo), .voltage_peak(vpeak),
        .vrms_below_on(vb), .vrms_above_off(va), .v_rms(vr), .i_rms(ir), .active_power(ap),
        .full_scale_line_peak(pk), .integrate_power(ip), .integrate_en(ie),
        .apparent_sel(asel), .tamper_en(te), .stepper_pos_drv(pd), .stepper_neg_drv(nd),
        .energy_pulse_drv(ed), .stepper_drive_pos_in(prb), .stepper_drive_neg_in(nrb),
        .energy_pulse_in(lrb), .stepper_drive_pos(pp), .stepper_drive_neg(np),
        .energy_pulse_pin(lp), .no_load_pin(nlp));
    msv_front_model i_msv_front_model (
        .pclk(pclk), .stuck_ch(sc), .stuck_one(s1), .pin_short(sh), .no_peak(nopk),
        .pos_pin(pp), .neg_pin(np), .led_pin(lp), .sd_bits(sdi), .peak(vpeak), .pos_rb(prb),
        .neg_rb(nrb), .led_rb(lrb));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic exp_no_load(input logic [15:0] v, input logic [15:0] c,
                                         input logic ct, input logic [1:0] lvl);
        logic [31:0] base;
        base = ct ? msv_pkg::NL_BASE_CT : msv_pkg::NL_BASE_ROG;
        return (32'(v) * 32'(c)) < (base << lvl);
    endfunction : exp_no_load

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (ready !== 1'b1);
        q = prdata;
        ee = err;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    initial begin
        {presetn, psel, penable, pwrite, sl, vb, va, pd, nd, ed, nopk, sh, s1} = '0;
        {paddr, pwdata, ap, sc} = '0;
        vr = 16'hffff; ir = 16'hffff; pk = 16'h8000;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 8'h40, 0); chk(ee, 1); chk(q, 0);
        for (int i = 0; i < 16; i++) begin
            ir <= 16'h8000 | 16'($random(seed)); pk <= 16'h8000 | 16'($random(seed));
            ap <= $random(seed);
            apb(1, msv_pkg::OFF_IRQ_MASK, {31'h0, i[0]});
            apb(1, msv_pkg::OFF_CONFIG, {28'h0, i[3:2], i[1:0]});
            vb <= 1'b1;
            repeat (6) @(posedge pclk);
            k = 32'((32'(pk) * kt[i[3:2]]) >> 16);
            apb(0, ST, 0); chk(q[0], !i[1]);
            chk(asel, !i[1]);
            chk(ip, !i[1] ? 32'(ir) * k[15:0] : ap);
            chk(irq, i[0] && !i[1]);
            vb <= 1'b0; va <= 1'b1;
            repeat (6) @(posedge pclk);
            va <= 1'b0;
            apb(0, ST, 0); chk(q[1:0], 0);
            chk(ip, ap);
            apb(0, msv_pkg::OFF_IRQ_STAT, 0); chk(irq, 0);
        end
        $display("test single wire done");
        pd <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            vr <= 16'h1000 | 16'($random(seed) & 12'hfff); ir <= 16'($random(seed)) & 16'h3fff;
            cs = 2'($random(seed));
            apb(1, msv_pkg::OFF_CONFIG, {26'h0, i[1:0], 2'h0, cs});
            repeat (4) @(posedge pclk);
            apb(0, msv_pkg::OFF_CONFIG, 0); chk(q, {26'h0, i[1:0], 2'h0, cs});
            k[0] = exp_no_load(vr, ir, cs[1], i[1:0]);
            apb(0, ST, 0); chk(q[2], k[0]);
            chk(nlp, !k[0]); chk(pp, !k[0]);
            chk(ie, !k[0]); chk(te, !k[0]);
        end
        vr <= 16'hffff; ir <= 16'hffff;
        $display("test no load done");
        for (int i = 0; i < 3; i++) begin
            sc <= 3'h1 << i; s1 <= i[0];
            repeat (300) @(posedge pclk);
            apb(0, ST, 0); chk(q[5:3], 3'h1 << i);
            chk(ie, 0);
            k[0] = sdo[i];
            @(posedge pclk);
            chk(sdo[i], !k[0]);
            sc <= 3'h0;
            repeat (300) @(posedge pclk);
            apb(0, ST, 0); chk(q[5:3], 0);
        end
        $display("test stuck stream done");
        nd <= 1'b1; ed <= 1'b1; sh <= 1'b1;
        repeat (10) @(posedge pclk);
        apb(0, ST, 0); chk(q[6], 1);
        chk({np, lp}, 2'h3);
        chk(ie, 0);
        sh <= 1'b0;
        repeat (10) @(posedge pclk);
        apb(0, ST, 0); chk(q[6], 0);
        $display("test pin mismatch done");
        nopk <= 1'b1;
        repeat (450) @(posedge pclk);
        apb(0, ST, 0); chk(q[1], 1);
        chk(ie, 0);
        nopk <= 1'b0;
        repeat (450) @(posedge pclk);
        apb(0, ST, 0); chk(q[1], 0);
        $display("test missing peaks done");
        apb(1, msv_pkg::OFF_CONFIG, 32'h3f);
        sl <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(0, msv_pkg::OFF_CONFIG, 0); chk(q, 0);
        chk(pp, 0); chk(ip, 0);
        $display("test supply low done");
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
